//--- design/cpcp_cfg.svh
// constants for the copper port crossover/polarity block: offsets, fields, resets, timing
// assumes inclusion by bare name from the package and the top module
`ifndef CPCP_CFG_SVH
`define CPCP_CFG_SVH

`define CPCP_NPORT        8                 // copper ports
`define CPCP_NPAIR        4                 // media pairs per port
`define CPCP_CLK_KHZ      25000             // pclk rate in kHz
`define CPCP_SAMPLE_MS    62                // crossover sample window in ms
`define CPCP_SAMPLE_CYC   (`CPCP_SAMPLE_MS * `CPCP_CLK_KHZ)

// speed codes
`define CPCP_SPD_10       2'h0
`define CPCP_SPD_100      2'h1
`define CPCP_SPD_1000     2'h2

// ability bit positions in advert/partner words
`define CPCP_ABL_10       0
`define CPCP_ABL_100      1
`define CPCP_ABL_1000     2

// register byte offsets
`define CPCP_OFS_AN_DIS   8'h00
`define CPCP_OFS_XO_DIS   8'h04
`define CPCP_OFS_XO_FIX   8'h08
`define CPCP_OFS_FORCE    8'h0c
`define CPCP_OFS_ADVERT   8'h10
`define CPCP_OFS_LINK     8'h14
`define CPCP_OFS_CROSSED  8'h18
`define CPCP_OFS_SPEED    8'h1c

// reset values
`define CPCP_RST_AN_DIS   8'h00
`define CPCP_RST_XO_DIS   8'h00
`define CPCP_RST_XO_FIX   8'h00
`define CPCP_RST_FORCE    16'haaaa
`define CPCP_RST_ADVERT   3'h7
`define CPCP_LFSR_SEED    11'h5a5

`endif

//--- design/cpcp_pkg.sv
// types for the copper port crossover/polarity block
// assumes cpcp_cfg.svh is on the include path
`include "cpcp_cfg.svh"

package cpcp_pkg;
    typedef logic [1:0] cpcp_speed_t;             // one of the speed codes
    typedef logic [2:0] cpcp_ability_t;           // 10/100/1000 ability mask
    typedef enum logic [1:0] {
        ST_HUNT,                                  // searching pair mapping
        ST_NEGOT,                                 // mapping locked, resolving speed
        ST_LINK                                   // link up
    } cpcp_port_st_t;
endpackage : cpcp_pkg

//--- design/cpcp_sync.sv
// two flip-flop synchroniser for a bus of independent levels
// assumes each bit is a quasi-static level; no word coherency across bits
`timescale 1ns/1ps
`default_nettype none

module cpcp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;                       // first stage, read only by second

    // two stages, nothing else looks at meta
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule : cpcp_sync

`default_nettype wire

//--- design/cpcp_top.sv
// copper port crossover, speed and polarity control for eight twisted-pair ports
// assumes async pair/partner indications from the analog front end, APB from the switch cpu
//
// Overview of operation
// - every port runs at 10, 100 or 1000; a forced code 3 is taken as is
// - negotiate highest speed both sides advertise
// - setting disables negotiation, forces chosen speed
// - automatic crossover enabled by default everywhere
// - straight/crossed pair mapping per speed, swapped pairs
// - fixed partner: pick mapping before negotiating
// - capable partner: randomized crossover resolution
// - setting disables automatic crossover per port
// - correct receive polarity at 1000 and 10
`timescale 1ns/1ps
`default_nettype none
`include "cpcp_cfg.svh"

module cpcp_top
    import cpcp_pkg::*;
#(
    parameter int NPORT      = `CPCP_NPORT,
    parameter int SAMPLE_CYC = `CPCP_SAMPLE_CYC     // shorten in simulation
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NPORT*4-1:0]    pair_energy,
    input  wire logic [NPORT*4-1:0]    pair_rx_inverted,
    input  wire logic [NPORT*3-1:0]    partner_ability,
    input  wire logic [NPORT-1:0]      partner_page_valid,
    output logic      [NPORT-1:0]      link_up,
    output logic      [NPORT-1:0]      pair_crossed,
    output logic      [NPORT*2-1:0]    port_speed,
    output logic      [NPORT*4-1:0]    media_pair_lines_tx_en,
    output logic      [NPORT*4-1:0]    pol_fix
);
    localparam int SYNC_W = NPORT * 12;

    // configuration held by software
    logic [7:0]           an_dis;                 // per-port negotiation off
    logic [7:0]           xo_dis;                 // per-port auto crossover off
    logic [7:0]           xo_fix;                 // fixed mapping when crossover off
    logic [15:0]          force_speed;            // two bits per port
    cpcp_ability_t        advert;                 // local abilities

    // synchronised front-end levels
    logic [SYNC_W-1:0]    sync_q;
    logic [NPORT*4-1:0]   energy_s;
    logic [NPORT*4-1:0]   inv_s;
    logic [NPORT*3-1:0]   abl_s;
    logic [NPORT-1:0]     page_s;

    // every front-end pin input passes two flops before any logic reads it; apb inputs are used directly
    cpcp_sync #(.WIDTH(SYNC_W)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({partner_page_valid, partner_ability, pair_rx_inverted, pair_energy}),
        .sync_out (sync_q)
    );

    assign energy_s = sync_q[NPORT*4-1:0];
    assign inv_s    = sync_q[NPORT*8-1:NPORT*4];
    assign abl_s    = sync_q[NPORT*11-1:NPORT*8];
    assign page_s   = sync_q[NPORT*12-1:NPORT*11];

    // apb access phase qualifier
    logic apb_wr;
    assign apb_wr = psel & penable & pready & pwrite;

    // zero-wait slave: pready high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // read data and error captured during setup, stable through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            case (paddr)
                `CPCP_OFS_AN_DIS:  prdata <= {24'h00_0000, an_dis};
                `CPCP_OFS_XO_DIS:  prdata <= {24'h00_0000, xo_dis};
                `CPCP_OFS_XO_FIX:  prdata <= {24'h00_0000, xo_fix};
                `CPCP_OFS_FORCE:   prdata <= {16'h0000, force_speed};
                `CPCP_OFS_ADVERT:  prdata <= {29'h0000_0000, advert};
                `CPCP_OFS_LINK:    prdata <= {24'h00_0000, link_up};
                `CPCP_OFS_CROSSED: prdata <= {24'h00_0000, pair_crossed};
                `CPCP_OFS_SPEED:   prdata <= {16'h0000, port_speed};
                default: begin                     // unmapped: zero data, error
                    prdata  <= 32'h0000_0000;
                    pslverr <= 1'b1;
                end
            endcase
        end else begin
            pslverr <= 1'b0;                       // error stands with pready only
        end
    end

    // configuration writes; read-only and unmapped words ignore writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            an_dis      <= `CPCP_RST_AN_DIS;
            xo_dis      <= `CPCP_RST_XO_DIS;
            xo_fix      <= `CPCP_RST_XO_FIX;
            force_speed <= `CPCP_RST_FORCE;
            advert      <= `CPCP_RST_ADVERT;
        end else if (apb_wr) begin
            case (paddr)
                `CPCP_OFS_AN_DIS: an_dis      <= pwdata[7:0];
                `CPCP_OFS_XO_DIS: xo_dis      <= pwdata[7:0];
                `CPCP_OFS_XO_FIX: xo_fix      <= pwdata[7:0];
                `CPCP_OFS_FORCE:  force_speed <= pwdata[15:0];
                `CPCP_OFS_ADVERT: advert      <= pwdata[2:0];
                default: begin                     // nothing stored
                end
            endcase
        end
    end

    // one identical controller per copper port
    genvar g;
    for (g = 0; g < NPORT; g++) begin : g_port
        cpcp_port_st_t state;                     // port state
        logic [31:0]   timer;                     // crossover sample window
        logic [10:0]   lfsr;                      // random toggle source
        logic          crossed;                   // current pair mapping
        logic          link;                      // link indication
        cpcp_speed_t   speed;                     // resolved speed
        logic [3:0]    tx_en;                     // pairs being driven
        logic [3:0]    pfix;                      // polarity inversions applied
        logic          rx_live;                   // energy on the receive pair
        cpcp_ability_t common;                    // shared abilities
        cpcp_speed_t   best;                      // fastest shared speed
        logic [3:0]    inv;                       // synced polarity readings

        // receive pair is 1 straight, 0 crossed
        assign rx_live = crossed ? energy_s[g*4] : energy_s[g*4+1];
        assign common  = advert & abl_s[g*3 +: 3];
        assign inv     = inv_s[g*4 +: 4];

        // fastest speed both ends advertise
        always_comb begin
            if (common[`CPCP_ABL_1000]) begin
                best = `CPCP_SPD_1000;
            end else if (common[`CPCP_ABL_100]) begin
                best = `CPCP_SPD_100;
            end else begin
                best = `CPCP_SPD_10;
            end
        end

        // free-running lfsr, distinct seed per port so two ends rarely stay in step
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lfsr <= `CPCP_LFSR_SEED ^ 11'(g);
            end else begin
                lfsr <= {lfsr[9:0], lfsr[10] ^ lfsr[8]};
            end
        end

        // port state machine: hunt mapping, then speed, then link
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                state   <= ST_HUNT;
                timer   <= 32'h0000_0000;
                crossed <= 1'b0;
                link    <= 1'b0;
                speed   <= `CPCP_SPD_1000;
            end else begin
                case (state)
                    ST_HUNT: begin
                        link <= 1'b0;
                        if (xo_dis[g]) begin
                            crossed <= xo_fix[g];
                            timer   <= 32'h0000_0000;
                            if (rx_live && crossed == xo_fix[g]) begin
                                state <= ST_NEGOT;
                            end
                        end else if (rx_live) begin
                            timer <= 32'h0000_0000;
                            state <= ST_NEGOT;
                        end else if (timer == 32'(SAMPLE_CYC - 1)) begin
                            timer <= 32'h0000_0000;
                            if (lfsr[0]) begin
                                crossed <= ~crossed;
                            end
                        end else begin
                            timer <= timer + 32'h0000_0001;
                        end
                    end
                    ST_NEGOT: begin
                        if (!rx_live) begin
                            state <= ST_HUNT;             // partner gone, search again
                        end else if (an_dis[g]) begin
                            speed <= force_speed[g*2 +: 2];
                            link  <= 1'b1;
                            state <= ST_LINK;
                        end else if (page_s[g] && common != 3'h0) begin
                            speed <= best;
                            link  <= 1'b1;
                            state <= ST_LINK;
                        end
                    end
                    ST_LINK: begin
                        // leaving link on energy loss; config changes apply at next hunt
                        if (!rx_live) begin
                            link  <= 1'b0;
                            state <= ST_HUNT;
                        end
                    end
                    default: begin
                        state <= ST_HUNT;
                        link  <= 1'b0;
                    end
                endcase
            end
        end

        // driven pairs: all four at gigabit, one transmit pair otherwise
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                tx_en <= 4'h1;
            end else if (link && speed == `CPCP_SPD_1000) begin
                tx_en <= 4'hf;
            end else begin
                tx_en <= crossed ? 4'h2 : 4'h1;
            end
        end

        // polarity fix on receive pairs; 100 mode ignores polarity
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pfix <= 4'h0;
            end else if (!link) begin
                pfix <= 4'h0;
            end else begin
                case (speed)
                    `CPCP_SPD_1000: pfix <= inv;
                    `CPCP_SPD_10:   pfix <= crossed ? {3'h0, inv[0]}
                                                    : {2'h0, inv[1], 1'b0};
                    default:        pfix <= 4'h0;
                endcase
            end
        end

        // outputs straight from the per-port flops
        assign link_up[g]                   = link;
        assign pair_crossed[g]              = crossed;
        assign port_speed[g*2 +: 2]         = speed;
        assign media_pair_lines_tx_en[g*4 +: 4] = tx_en;
        assign pol_fix[g*4 +: 4]            = pfix;
    end
endmodule : cpcp_top

`default_nettype wire

//--- dv/cpcp_partner.sv
// remote link partners on the eight cables, straight cable assumed
// assumes tx_en comes from the block; config comes from the bench
`timescale 1ns/1ps
`default_nettype none
module cpcp_partner #(
    parameter int NPORT = 8
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic [NPORT-1:0]   present,
    input  wire logic [NPORT-1:0]   auto_xo,
    input  wire logic [NPORT-1:0]   fix_map,
    input  wire logic [NPORT*3-1:0] ability,
    input  wire logic [NPORT*4-1:0] inv,
    input  wire logic [NPORT*4-1:0] tx_en,
    output logic      [NPORT*4-1:0] pair_energy,
    output logic      [NPORT*4-1:0] pair_rx_inverted,
    output logic      [NPORT*3-1:0] partner_ability,
    output logic      [NPORT-1:0]   partner_page_valid
);
    logic [NPORT-1:0] map;   // 1 = partner crossed
    logic [7:0]       tick;  // own pace, unrelated to ours so hunting cannot lock step
    logic [4:0]       rnd;   // partner coin
    // pace and coin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick <= 8'h0;
            rnd  <= 5'h13;
        end else begin
            tick <= (tick == 8'h16) ? 8'h0 : tick + 8'h1;
            rnd  <= {rnd[3:0], rnd[4] ^ rnd[2]};
        end
    end
    // fixed partner, or one that flips until it hears us
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) map <= '0;
        else for (int p = 0; p < NPORT; p++) begin
            if (!auto_xo[p]) map[p] <= fix_map[p];
            else if (tick == 8'h0 && rnd[0] && !partner_page_valid[p]) map[p] <= ~map[p];
        end
    end
    // lines as our port sees them; absent partner is silent, ability lines wander
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_energy        <= '0;
            pair_rx_inverted   <= '0;
            partner_ability    <= '0;
            partner_page_valid <= '0;
        end else for (int p = 0; p < NPORT; p++) begin
            pair_energy[p*4+:4]      <= present[p] ? (map[p] ? 4'h2 : 4'h1) : 4'h0;
            pair_rx_inverted[p*4+:4] <= present[p] ? inv[p*4+:4] : 4'h0;
            partner_ability[p*3+:3]  <= present[p] ? ability[p*3+:3] : ~partner_ability[p*3+:3];
            partner_page_valid[p]    <= present[p] & tx_en[p*4 + (map[p] ? 0 : 1)];
        end
    end
endmodule : cpcp_partner
`default_nettype wire

//--- dv/cpcp_top_sva.sv
// checker for the copper port block, watching port 0 lanes and the apb slave
// assumes bind onto cpcp_top; the master keeps apb request order
`timescale 1ns/1ps
`default_nettype none
module cpcp_top_sva #(
    parameter int NPORT      = 8,
    parameter int SAMPLE_CYC = 16
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic [NPORT*4-1:0] pair_energy,
    input wire logic [NPORT*4-1:0] pair_rx_inverted,
    input wire logic [NPORT*3-1:0] partner_ability,
    input wire logic [NPORT-1:0]   partner_page_valid,
    input wire logic [NPORT-1:0]   link_up,
    input wire logic [NPORT-1:0]   pair_crossed,
    input wire logic [NPORT*2-1:0] port_speed,
    input wire logic [NPORT*4-1:0] media_pair_lines_tx_en,
    input wire logic [NPORT*4-1:0] pol_fix
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // both receive candidates silent
    sequence s_rx_quiet;
        pair_energy[1:0] == 2'h0;
    endsequence
    // link seen on two samples running
    sequence s_held;
        link_up[0] && $past(link_up[0]);
    endsequence
    // lost energy must drop the link, sync delay included
    a_link_drop: assert property ((link_up[0] and s_rx_quiet) ##1 s_rx_quiet [*3] |=> !link_up[0])
        else $error("link kept without receive energy");
    a_map_hold: assert property (s_held |-> $stable(pair_crossed[0]))
        else $error("mapping moved during link");
    a_speed_hold: assert property (s_held |-> $stable(port_speed[1:0]))
        else $error("speed moved during link");
    a_tx_map: assert property (1'b1 |-> media_pair_lines_tx_en[3:0] ==
        (($past(link_up[0]) && $past(port_speed[1:0]) == 2'h2) ? 4'hf :
        ($past(pair_crossed[0]) ? 4'h2 : 4'h1)))
        else $error("driven pairs do not match mapping");
    a_pol_quiet: assert property ((!$past(link_up[0]) || $past(port_speed[0])) |->
        pol_fix[3:0] == 4'h0)
        else $error("polarity fixed without link or at 100");
    a_pol_ten: assert property (($past(link_up[0]) && $past(port_speed[1:0]) == 2'h0) |->
        (pol_fix[3:0] & ~($past(pair_crossed[0]) ? 4'h1 : 4'h2)) == 4'h0)
        else $error("polarity fix beyond receive pair at 10");
    a_pol_gig: assert property ((link_up[0] && port_speed[1:0] == 2'h2 &&
        $stable(pair_rx_inverted[3:0])) [*5] |-> pol_fix[3:0] == pair_rx_inverted[3:0])
        else $error("gigabit polarity not corrected");
    // zero wait slave; one-cycle answer
    a_apb_answer: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : cpcp_top_sva
bind cpcp_top cpcp_top_sva #(.NPORT(NPORT), .SAMPLE_CYC(SAMPLE_CYC)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pair_energy(pair_energy), .pair_rx_inverted(pair_rx_inverted),
    .partner_ability(partner_ability), .partner_page_valid(partner_page_valid),
    .link_up(link_up), .pair_crossed(pair_crossed), .port_speed(port_speed),
    .media_pair_lines_tx_en(media_pair_lines_tx_en), .pol_fix(pol_fix));
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench: apb master, random partners, forced speed and crossover corners
// assumes cpcp_top with a short sample window and the partner model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %s exp %0h got %0h", nm, (e), (g)); end end
module tb_top;
    import cpcp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr;
    logic [31:0] energy, rx_inv, tx_en, pol_fix, inv = 32'h0;
    logic [23:0] p_abl, ability = 24'h0;
    logic [15:0] port_speed;
    logic [7:0]  page_ok, link_up, pair_crossed, present = 8'h0, auto_xo = 8'h0, fix_map = 8'h0;
    int          fails = 0, checks_done = 0;
    logic [31:0] s;
    logic [2:0]  adv, ab;
    logic [31:0] rst_tab [8] = '{32'h0, 32'h0, 32'h0, 32'haaaa, 32'h7, 32'h0, 32'h0, 32'haaaa};
    always #20 pclk = ~pclk;  // 25 MHz
    cpcp_top #(.SAMPLE_CYC(16)) u_cpcp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pair_energy(energy), .pair_rx_inverted(rx_inv),
        .partner_ability(p_abl), .partner_page_valid(page_ok), .link_up(link_up),
        .pair_crossed(pair_crossed), .port_speed(port_speed),
        .media_pair_lines_tx_en(tx_en), .pol_fix(pol_fix));
    cpcp_partner u_cpcp_partner (.pclk(pclk), .presetn(presetn), .present(present),
        .auto_xo(auto_xo), .fix_map(fix_map), .ability(ability), .inv(inv), .tx_en(tx_en),
        .pair_energy(energy), .pair_rx_inverted(rx_inv), .partner_ability(p_abl),
        .partner_page_valid(page_ok));
    // bench random source
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // fastest common speed code
    function automatic logic [1:0] fastest(input logic [2:0] c);
        return c[2] ? 2'h2 : (c[1] ? 2'h1 : 2'h0);
    endfunction : fastest
    // expected polarity fix: all pairs at 1000, receive pair at 10, none otherwise
    function automatic logic [3:0] pexp(input logic [1:0] spd, input logic [3:0] iv,
                                        input logic [3:0] rxm);
        return (spd == 2'h2) ? iv : ((spd == 2'h0) ? (iv & rxm) : 4'h0);
    endfunction : pexp
    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // one apb transfer, entered just after an edge; leaves one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 64) fails++;
        if (n >= 64) give_verdict();
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK("rdata", x, r)
        `CHK("slverr", xe, e)
    endtask : rd_chk
    // bounded wait for a link level; running out counts as a mismatch
    task automatic wait_link(input int p, input logic want);
        int n;
        n = 0;
        while (link_up[p] !== want && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) fails++;
        if (n >= 3000) give_verdict();
    endtask : wait_link
    // linked port: speed, mapping, driven pairs, polarity, speed register
    task automatic chk_port(input int p, input logic [1:0] spd, input logic [3:0] iv);
        logic [3:0]  rxm;
        logic [31:0] r;
        logic        e;
        repeat (6) @(posedge pclk);
        rxm = pair_crossed[p] ? 4'h1 : 4'h2;
        `CHK("link", 1'b1, link_up[p])
        `CHK("speed", spd, port_speed[p*2+:2])
        `CHK("rx_energy", 4'h0, ~energy[p*4+:4] & rxm)
        `CHK("tx_en", (spd == 2'h2) ? 4'hf : {2'h0, rxm[0], rxm[1]}, tx_en[p*4+:4])
        `CHK("pol_fix", pexp(spd, iv, rxm), pol_fix[p*4+:4])
        apb(1'b0, 8'h1c, 32'h0, r, e);
        `CHK("speed_reg", spd, r[p*2+:2])
    endtask : chk_port
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // status words first, before the hunt timer may move a mapping
        for (int k = 5; k < 13; k++) rd_chk(8'((k % 8) * 4), rst_tab[k % 8], 1'b0);
        wr(8'h14, 32'hff);
        rd_chk(8'h14, 32'h0, 1'b0);
        rd_chk(8'h20, 32'h0, 1'b1);
        s = lfsr(32'ha46a);
        adv = (s[2:0] == 3'h0) ? 3'h6 : s[2:0];
        wr(8'h10, {29'h0, adv});
        // random partners; last port shares no speed with us
        for (int p = 0; p < 8; p++) begin
            s = lfsr(s);
            ab = (p == 7) ? ~adv : s[2:0];
            auto_xo[p]      <= s[3];
            fix_map[p]      <= s[4];
            ability[p*3+:3] <= ab;
            inv[p*4+:4]     <= s[11:8];
            present[p]      <= 1'b1;
            @(posedge pclk);
            if ((ab & adv) == 3'h0) repeat (400) @(posedge pclk);
            else wait_link(p, 1'b1);
            if ((ab & adv) == 3'h0) `CHK("no_common", 1'b0, link_up[p])
            else chk_port(p, fastest(ab & adv), s[11:8]);
            if (!s[3] && (ab & adv) != 3'h0) `CHK("fixed_partner", ~s[4], pair_crossed[p])
        end
        // forced speeds on port 0, code 3 among them
        wr(8'h00, 32'h1);
        for (int c = 0; c < 4; c++) begin
            wr(8'h0c, 32'(c));
            present[0] <= 1'b0;
            wait_link(0, 1'b0);
            present[0] <= 1'b1;
            wait_link(0, 1'b1);
            chk_port(0, 2'(c), inv[3:0]);
        end
        // crossover off on port 1: wrong fixed mapping refuses, right one links at 10
        auto_xo[1] <= 1'b0;
        fix_map[1] <= 1'b1;
        present[1] <= 1'b0;
        wait_link(1, 1'b0);
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h2);
        wr(8'h08, 32'h2);
        present[1] <= 1'b1;
        repeat (400) @(posedge pclk);
        `CHK("xo_hold_link", 1'b0, link_up[1])
        `CHK("xo_hold_map", 1'b1, pair_crossed[1])
        wr(8'h08, 32'h0);
        wait_link(1, 1'b1);
        `CHK("xo_fix_map", 1'b0, pair_crossed[1])
        chk_port(1, 2'h0, inv[7:4]);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
